// [include/light_sensor_defs.vh]
// constants shared by the light sensor readout design files
`ifndef LIGHT_SENSOR_DEFS_VH
`define LIGHT_SENSOR_DEFS_VH

// ----------------------------------------------------------------
// serial link
// ----------------------------------------------------------------
`define SLV_ADDR        7'h44
`define BIT_CNT_W       4
`define BIT_CNT_ZERO    4'h0
`define BIT_CNT_ONE     4'h1
`define BIT_CNT_BYTE    4'h8

// ----------------------------------------------------------------
// register pointers and reset values
// ----------------------------------------------------------------
`define PTR_CTRL        8'h00
`define PTR_RESULT      8'h01
`define CTRL_RST        8'h00
`define RESULT_RST      16'h0000
`define BYTE_ZERO       8'h00

// ----------------------------------------------------------------
// conversion_control fields
// ----------------------------------------------------------------
`define CTRL_EN_BIT     7
`define CTRL_CONT_BIT   6
`define CTRL_IR_BIT     5
`define CTRL_RES_MSB    3
`define CTRL_RES_LSB    2
`define CTRL_RANGE_MSB  1
`define CTRL_RANGE_LSB  0

// ----------------------------------------------------------------
// resolution select: integration periods (2^n)
// ----------------------------------------------------------------
`define RES_16          2'b00
`define RES_12          2'b01
`define RES_8           2'b10
`define RES_4           2'b11
`define PERIODS_16      17'h10000
`define PERIODS_12      17'h01000
`define PERIODS_8       17'h00100
`define PERIODS_4       17'h00010
`define PERIOD_ONE      17'h00001
`define PERIOD_ZERO     17'h00000

// ----------------------------------------------------------------
// range select: photodetector pulses per count (sensitivity)
// ----------------------------------------------------------------
`define RANGE_1000      2'b00
`define RANGE_4000      2'b01
`define RANGE_16000     2'b10
`define RANGE_64000     2'b11
`define PRE_MASK_1000   6'h00
`define PRE_MASK_4000   6'h03
`define PRE_MASK_16000  6'h0f
`define PRE_MASK_64000  6'h3f
`define PRE_ZERO        6'h00
`define PRE_ONE         6'h01
`define COUNT_ZERO      16'h0000
`define COUNT_ONE       16'h0001

// ----------------------------------------------------------------
// internal oscillator: one tick every OSC_DIV+1 clock cycles
// ----------------------------------------------------------------
`define OSC_DIV         4'h9
`define OSC_ZERO        4'h0
`define OSC_ONE         4'h1

`endif

// [hw/light_integrator.v]
// integration counter of the light converter, timed by the internal oscillator
`timescale 1ns/1ps
`default_nettype none
`include "light_sensor_defs.vh"

module light_integrator (
    input  wire        i_clk,      // system clock
    input  wire        i_rst_n,    // synchronous reset, active low
    input  wire        i_tick,     // internal oscillator period pulse
    input  wire        i_enable,   // converter running
    input  wire        i_restart,  // start a fresh integration
    input  wire        i_pulse,    // one photodetector event
    input  wire [1:0]  i_res_sel,  // resolution select
    input  wire [1:0]  i_range,    // full_scale_range select
    output reg         o_done,     // one-cycle pulse, result ready
    output reg  [15:0] o_count     // last completed result
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // number of oscillator periods in one integration
    function [16:0] period_limit;
        input [1:0] sel;
        begin
            case (sel)
                `RES_16: period_limit = `PERIODS_16;
                `RES_12: period_limit = `PERIODS_12;
                `RES_8:  period_limit = `PERIODS_8;
                default: period_limit = `PERIODS_4;
            endcase
        end
    endfunction

    // prescale mask: larger range means fewer counts per event
    function [5:0] pre_mask;
        input [1:0] rng;
        begin
            case (rng)
                `RANGE_1000:  pre_mask = `PRE_MASK_1000;
                `RANGE_4000:  pre_mask = `PRE_MASK_4000;
                `RANGE_16000: pre_mask = `PRE_MASK_16000;
                default:      pre_mask = `PRE_MASK_64000;
            endcase
        end
    endfunction

    reg  [16:0] per_q;     // elapsed oscillator periods
    reg  [5:0]  pre_q;     // event prescaler
    reg  [15:0] cnt_q;     // running count
    wire [16:0] limit;     // periods in this integration
    wire [16:0] max_cnt;   // largest count, 2^n - 1
    wire        hit;       // event that advances the count

    assign limit   = period_limit(i_res_sel);
    assign max_cnt = limit - `PERIOD_ONE;
    assign hit     = i_pulse && ((pre_q & pre_mask(i_range)) == pre_mask(i_range));

    // ----------------------------------------------------------------
    // integration: 2^n periods, count saturates at 2^n - 1
    // ----------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            per_q   <= `PERIOD_ZERO;
            pre_q   <= `PRE_ZERO;
            cnt_q   <= `COUNT_ZERO;
            o_done  <= 1'b0;
            o_count <= `COUNT_ZERO;
        end else begin
            o_done <= 1'b0;
            if (!i_enable || i_restart) begin
                // halted or restarted: drop partial work, keep o_count
                per_q <= `PERIOD_ZERO;
                pre_q <= `PRE_ZERO;
                cnt_q <= `COUNT_ZERO;
            end else begin
                if (i_pulse) begin
                    pre_q <= pre_q + `PRE_ONE;
                end
                if (hit && ({1'b0, cnt_q} < max_cnt)) begin
                    cnt_q <= cnt_q + `COUNT_ONE;
                end
                if (i_tick) begin
                    if (per_q == max_cnt) begin
                        // last period: publish and start over
                        o_done  <= 1'b1;
                        o_count <= cnt_q;
                        per_q   <= `PERIOD_ZERO;
                        pre_q   <= `PRE_ZERO;
                        cnt_q   <= `COUNT_ZERO;
                    end else begin
                        per_q <= per_q + `PERIOD_ONE;
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// [hw/light_sensor_top.v]
// light sensor: two-wire slave, conversion_control and conversion_result
`timescale 1ns/1ps
`default_nettype none
`include "light_sensor_defs.vh"

module light_sensor_top (
    input  wire i_clk,        // system clock, 100 MHz
    input  wire i_rst_n,      // synchronous reset, active low
    input  wire i_scl,        // serial clock pin
    input  wire i_sda,        // serial data pin, level on the wire
    input  wire i_vis_light,  // visible photodetector event train
    input  wire i_ir_light,   // infrared photodetector event train
    output reg  o_sda_out,    // serial data drive value, always low
    output reg  o_sda_oe_n,   // low while pulling the data line low
    output reg  o_converting  // converter running
);

    // ----------------------------------------------------------------
    // link states
    // ----------------------------------------------------------------
    localparam [3:0] ST_IDLE  = 4'h0; // waiting for a start
    localparam [3:0] ST_ADDR  = 4'h1; // receiving address byte
    localparam [3:0] ST_AACK  = 4'h2; // acknowledging address
    localparam [3:0] ST_PTR   = 4'h3; // receiving pointer byte
    localparam [3:0] ST_PACK  = 4'h4; // acknowledging pointer
    localparam [3:0] ST_WDAT  = 4'h5; // receiving data byte
    localparam [3:0] ST_WACK  = 4'h6; // acknowledging data
    localparam [3:0] ST_RDAT  = 4'h7; // sending data byte
    localparam [3:0] ST_RACK  = 4'h8; // sampling master acknowledge

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg [1:0] scl_sync_q;  // scl two-flop chain
    reg [1:0] sda_sync_q;  // sda two-flop chain
    reg [1:0] vis_sync_q;  // visible events two-flop chain
    reg [1:0] ir_sync_q;   // infrared events two-flop chain
    reg       scl_prev_q;  // scl one cycle later
    reg       sda_prev_q;  // sda one cycle later
    reg       vis_prev_q;  // visible one cycle later
    reg       ir_prev_q;   // infrared one cycle later

    // only stage 1 reads stage 0; all logic reads stage 1 and later
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            scl_sync_q <= 2'b11;
            sda_sync_q <= 2'b11;
            vis_sync_q <= 2'b00;
            ir_sync_q  <= 2'b00;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            vis_prev_q <= 1'b0;
            ir_prev_q  <= 1'b0;
        end else begin
            scl_sync_q <= {scl_sync_q[0], i_scl};
            sda_sync_q <= {sda_sync_q[0], i_sda};
            vis_sync_q <= {vis_sync_q[0], i_vis_light};
            ir_sync_q  <= {ir_sync_q[0], i_ir_light};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
            vis_prev_q <= vis_sync_q[1];
            ir_prev_q  <= ir_sync_q[1];
        end
    end

    wire scl     = scl_sync_q[1];             // settled scl
    wire sda     = sda_sync_q[1];             // settled sda
    wire scl_ris = scl && !scl_prev_q;        // scl rising edge
    wire scl_fal = !scl && scl_prev_q;        // scl falling edge
    wire start   = scl && scl_prev_q && !sda && sda_prev_q; // start or repeated start
    wire stop    = scl && scl_prev_q && sda && !sda_prev_q; // stop
    wire vis_evt = vis_sync_q[1] && !vis_prev_q; // visible event
    wire ir_evt  = ir_sync_q[1] && !ir_prev_q;   // infrared event

    // ----------------------------------------------------------------
    // registers and link state
    // ----------------------------------------------------------------
    reg  [7:0]             ctrl_q;     // conversion_control
    reg  [15:0]            result_q;   // conversion_result
    reg  [15:0]            snap_q;     // result frozen for one read
    reg  [7:0]             ptr_q;      // register pointer
    reg  [3:0]             state_q;    // link state
    reg  [`BIT_CNT_W-1:0]  bit_q;      // bits taken in current byte
    reg  [7:0]             rx_q;       // receive shifter
    reg  [7:0]             tx_q;       // transmit shifter
    reg                    hi_q;       // next read byte is upper half
    reg                    nack_q;     // master did not acknowledge
    reg                    wr_pulse_q; // control written this cycle
    reg                    active_q;   // converter running
    wire                   conv_done;  // integration finished
    wire [15:0]            conv_count; // integration result
    wire [7:0]             first_byte; // first byte of a read
    wire [7:0]             next_byte;  // following byte of a read

    // byte returned for a read at pointer p, half h
    function [7:0] read_byte;
        input [7:0]  p;
        input        h;
        input [7:0]  c;
        input [15:0] r;
        begin
            if (p == `PTR_CTRL) begin
                read_byte = c;
            end else if (p == `PTR_RESULT) begin
                read_byte = h ? r[15:8] : r[7:0];
            end else begin
                read_byte = `BYTE_ZERO;
            end
        end
    endfunction

    assign first_byte = read_byte(ptr_q, 1'b0, ctrl_q, result_q);
    assign next_byte  = read_byte(ptr_q, hi_q, ctrl_q, snap_q);

    // ----------------------------------------------------------------
    // two-wire slave: sample on scl rise, change sda on scl fall
    // ----------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_q    <= ST_IDLE;
            bit_q      <= `BIT_CNT_ZERO;
            rx_q       <= `BYTE_ZERO;
            tx_q       <= `BYTE_ZERO;
            ptr_q      <= `PTR_CTRL;
            ctrl_q     <= `CTRL_RST;
            snap_q     <= `RESULT_RST;
            hi_q       <= 1'b0;
            nack_q     <= 1'b0;
            wr_pulse_q <= 1'b0;
            o_sda_out  <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else begin
            wr_pulse_q <= 1'b0;
            o_sda_out  <= 1'b0;
            if (start) begin
                // new transaction or repeated start
                state_q    <= ST_ADDR;
                bit_q      <= `BIT_CNT_ZERO;
                o_sda_oe_n <= 1'b1;
            end else if (stop) begin
                state_q    <= ST_IDLE;
                o_sda_oe_n <= 1'b1;
            end else if (scl_ris) begin
                // sample data on rising clock
                if (state_q == ST_RACK) begin
                    nack_q <= sda;
                end else if (state_q == ST_RDAT) begin
                    bit_q <= bit_q + `BIT_CNT_ONE;
                end else if (state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_WDAT) begin
                    rx_q  <= {rx_q[6:0], sda};
                    bit_q <= bit_q + `BIT_CNT_ONE;
                end
            end else if (scl_fal) begin
                case (state_q)
                    ST_ADDR: begin
                        if (bit_q == `BIT_CNT_BYTE) begin
                            if (rx_q[7:1] == `SLV_ADDR) begin
                                // own address either direction: acknowledge
                                o_sda_oe_n <= 1'b0;
                                state_q    <= ST_AACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        bit_q <= `BIT_CNT_ZERO;
                        if (rx_q[0]) begin
                            // read: freeze result and drive first bit
                            snap_q     <= result_q;
                            hi_q       <= 1'b1;
                            tx_q       <= first_byte;
                            o_sda_oe_n <= first_byte[7];
                            state_q    <= ST_RDAT;
                        end else begin
                            o_sda_oe_n <= 1'b1;
                            state_q    <= ST_PTR;
                        end
                    end
                    ST_PTR: begin
                        if (bit_q == `BIT_CNT_BYTE) begin
                            ptr_q <= rx_q;
                            if (rx_q == `PTR_CTRL || rx_q == `PTR_RESULT) begin
                                o_sda_oe_n <= 1'b0;
                                state_q    <= ST_PACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_PACK, ST_WACK: begin
                        o_sda_oe_n <= 1'b1;
                        bit_q      <= `BIT_CNT_ZERO;
                        state_q    <= ST_WDAT;
                    end
                    ST_WDAT: begin
                        if (bit_q == `BIT_CNT_BYTE) begin
                            if (ptr_q == `PTR_CTRL) begin
                                // data byte after pointer 0x00
                                ctrl_q     <= rx_q;
                                wr_pulse_q <= 1'b1;
                                o_sda_oe_n <= 1'b0;
                                state_q    <= ST_WACK;
                            end else begin
                                // result is read only: refuse
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_RDAT: begin
                        if (bit_q == `BIT_CNT_BYTE) begin
                            o_sda_oe_n <= 1'b1;
                            state_q    <= ST_RACK;
                        end else begin
                            // next bit, most significant first
                            o_sda_oe_n <= tx_q[6];
                            tx_q       <= {tx_q[6:0], 1'b0};
                        end
                    end
                    ST_RACK: begin
                        bit_q <= `BIT_CNT_ZERO;
                        if (nack_q) begin
                            state_q <= ST_IDLE;
                        end else begin
                            // upper byte follows the lower byte
                            hi_q       <= !hi_q;
                            tx_q       <= next_byte;
                            o_sda_oe_n <= next_byte[7];
                            state_q    <= ST_RDAT;
                        end
                    end
                    default: begin
                        o_sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // internal oscillator divider
    // ----------------------------------------------------------------
    reg [3:0] osc_q;   // divider count
    reg       tick_q;  // one-cycle oscillator period pulse

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            osc_q  <= `OSC_ZERO;
            tick_q <= 1'b0;
        end else if (osc_q == `OSC_DIV) begin
            osc_q  <= `OSC_ZERO;
            tick_q <= 1'b1;
        end else begin
            osc_q  <= osc_q + `OSC_ONE;
            tick_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // conversion control
    // ----------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            active_q     <= 1'b0;
            result_q     <= `RESULT_RST;
            o_converting <= 1'b0;
        end else begin
            if (conv_done) begin
                // conv_done is captured even in a command write cycle; a write on the last tick restarts the integration and drops its count
                result_q <= conv_count;
            end
            if (wr_pulse_q) begin
                // new command: run only when enable bit set
                active_q <= ctrl_q[`CTRL_EN_BIT];
            end else if (conv_done && !ctrl_q[`CTRL_CONT_BIT]) begin
                // one-shot: stop, keep result readable
                active_q <= 1'b0;
            end
            o_converting <= active_q;
        end
    end

    // ----------------------------------------------------------------
    // converter
    // ----------------------------------------------------------------
    light_integrator u_integrator (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick_q),
        .i_enable  (active_q),
        .i_restart (wr_pulse_q),
        .i_pulse   (ctrl_q[`CTRL_IR_BIT] ? ir_evt : vis_evt),
        .i_res_sel (ctrl_q[`CTRL_RES_MSB:`CTRL_RES_LSB]),
        .i_range   (ctrl_q[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB]),
        .o_done    (conv_done),
        .o_count   (conv_count)
    );

endmodule
`default_nettype wire

// [verif/light_sensor_sva.sv]
// pin-level assertions for the light sensor
`timescale 1ns/1ps
`default_nettype none
module light_sensor_sva (
    input wire logic i_clk,       // system clock
    input wire logic i_rst_n,     // synchronous reset, active low
    input wire logic i_scl,       // link clock pin
    input wire logic i_sda,       // resolved data wire
    input wire logic i_vis_light, // visible events
    input wire logic i_ir_light,  // infrared events
    input wire logic o_sda_out,   // data drive value
    input wire logic o_sda_oe_n,  // low while pulling data low
    input wire logic o_converting // converter running
);
    // ----------------
    // pin relations
    // ----------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    drive_low_a: assert property (o_sda_out == 1'b0)
        else $error("data drive value not low");
    reset_idle_a: assert property ($rose(i_rst_n) |-> o_sda_oe_n && !o_converting)
        else $error("outputs not idle after reset");
    bit_edge_a: assert property ($changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl, 2))
        else $error("data pull changed outside clock low");
    bit_stable_a: assert property ($rose(i_scl) |-> $stable(o_sda_oe_n) [*6])
        else $error("data pull moved while clock high");
    bit_hold_a: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*8])
        else $error("data pull too short");
    conv_start_a: assert property ($rose(o_converting) |-> !o_sda_oe_n && !$past(i_scl, 3))
        else $error("converter started without a command write");
    conv_min_a: assert property ($rose(o_converting) |-> o_converting [*8])
        else $error("integration too short");
    conv_stop_a: assert property ($fell(o_converting) |-> !o_converting [*2])
        else $error("converter restarted by itself");
endmodule
bind light_sensor_top light_sensor_sva chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl),
    .i_sda(i_sda), .i_vis_light(i_vis_light), .i_ir_light(i_ir_light),
    .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_converting(o_converting));
`default_nettype wire

// [verif/i2c_host_model.sv]
// two-wire host that drives the sensor link
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    input  wire logic i_clk,      // bench clock
    input  wire logic i_sda,      // resolved data wire
    output var  logic o_scl,      // link clock, high when idle
    output var  logic o_sda_oe_n  // low while pulling data low
);
    // ----------------
    // link primitives
    // ----------------
    initial begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    // a quarter of the 160 ns link period, on falling edges
    task automatic q;
        repeat (4) @(negedge i_clk);
    endtask
    // data set while clock low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        q();
        o_sda_oe_n = b;
        q();
        o_scl = 1'b1;
        q();
        s = i_sda;
        q();
        o_scl = 1'b0;
    endtask
    // start and repeated start alike
    task automatic start;
        q();
        o_sda_oe_n = 1'b1;
        q();
        o_scl = 1'b1;
        q();
        o_sda_oe_n = 1'b0;
        q();
        o_scl = 1'b0;
    endtask
    // stop leaves both lines released
    task automatic stop;
        q();
        o_sda_oe_n = 1'b0;
        q();
        o_scl = 1'b1;
        q();
        o_sda_oe_n = 1'b1;
        q();
    endtask
    // byte out, msb first, then the sensor's acknowledge
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // byte in, msb first; last set means no acknowledge
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

// [verif/light_sensor_i2c_register_readout_tb_top.sv]
// self-checking bench for the light sensor readout
`timescale 1ns/1ps
`default_nettype none
module light_sensor_i2c_register_readout_tb_top;
    logic clk = 1'b0;     // system clock
    logic rst_n = 1'b0;   // reset, active low
    logic vis = 1'b0;     // visible event train
    logic ir = 1'b0;      // infrared event train
    logic scl;            // link clock from host
    logic h_oe_n;         // host pull on data
    logic s_out;          // sensor drive value
    logic s_oe_n;         // sensor pull on data
    logic conv;           // converter running
    int   n_mismatch = 0; // failed comparisons
    int   num_checks = 0; // comparisons made
    // pull-up unless a party pulls low
    wire  sda = !h_oe_n ? 1'b0 : (s_oe_n ? 1'b1 : s_out);
    always #5 clk = ~clk;
    light_sensor_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
        .i_vis_light(vis), .i_ir_light(ir), .o_sda_out(s_out), .o_sda_oe_n(s_oe_n),
        .o_converting(conv));
    i2c_host_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(h_oe_n));
    // ----------------
    // shared tasks
    // ----------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // pointer then one data byte, acknowledges compared
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic [2:0] ea);
        logic [2:0] a;
        host.start();
        host.wbyte(8'h88, a[2]);
        host.wbyte(p, a[1]);
        host.wbyte(d, a[0]);
        host.stop();
        chk({13'h0, a}, {13'h0, ea});
    endtask
    // pointer, repeated start, two bytes read
    task automatic rd(input logic [7:0] p, input logic [15:0] exp);
        logic [2:0] a;
        logic [15:0] v;
        host.start();
        host.wbyte(8'h88, a[2]);
        host.wbyte(p, a[1]);
        host.start();
        host.wbyte(8'h89, a[0]);
        host.rbyte(1'b0, v[7:0]);
        host.rbyte(1'b1, v[15:8]);
        host.stop();
        chk({13'h0, a}, 16'h0007);
        chk(v, exp);
    endtask
    // event pulses of 40 ns on each train
    task automatic burst(input int nv, input int ni);
        for (int i = 0; i < nv || i < ni; i++) begin
            vis = (i < nv);
            ir = (i < ni);
            cyc(4);
            vis = 1'b0;
            ir = 1'b0;
            cyc(4);
        end
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_refuse;
        logic a;
        host.start();
        host.wbyte(8'h8a, a);
        host.stop();
        chk({15'h0, a}, 16'h0000);
        rd(8'h01, 16'h0000);
        wr(8'h02, 8'h55, 3'b100);
        wr(8'h01, 8'h12, 3'b110);
    endtask
    // one-shot 12-bit visible, every fourth event counted
    task automatic t_oneshot;
        wr(8'h00, 8'h85, 3'b111);
        burst(40, 24);
        cyc(39000);
        chk({15'h0, conv}, 16'h0001);
        cyc(2000);
        chk({15'h0, conv}, 16'h0000);
        rd(8'h01, 16'h000a);
        rd(8'h00, 16'h8585);
    endtask
    // every range on 8-bit visible: larger range, fewer counts
    task automatic t_ranges;
        for (int r = 0; r < 4; r++) begin
            wr(8'h00, 8'h88 | 8'(r), 3'b111);
            burst(64, 0);
            cyc(2600);
            // host side: 250 lux at 2^8 periods gives range*count = 64000
            rd(8'h01, 16'(64000 / (1000 << (2 * r))));
        end
    endtask
    // 4-bit infrared, then power-down keeps result and settings
    task automatic t_ir_hold;
        wr(8'h00, 8'hac, 3'b111);
        burst(3, 6);
        cyc(300);
        rd(8'h01, 16'h0006);
        wr(8'h00, 8'h2c, 3'b111);
        burst(5, 5);
        chk({15'h0, conv}, 16'h0000);
        rd(8'h01, 16'h0006);
        rd(8'h00, 16'h2c2c);
    endtask
    // continuous runs on until told to stop
    task automatic t_cont;
        wr(8'h00, 8'hec, 3'b111);
        cyc(500);
        chk({15'h0, conv}, 16'h0001);
        wr(8'h00, 8'h6c, 3'b111);
        chk({15'h0, conv}, 16'h0000);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(6);
        rst_n = 1'b1;
        cyc(3);
        t_refuse();
        t_oneshot();
        t_ranges();
        t_ir_hold();
        t_cont();
        conclude();
    end
    // watchdog well past the expected run
    initial begin
        #1000000;
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire
